// ---- parallel_program_port.sv ----
// parallel programming port: command, address and data loading, page buffers,
// page programming of flash and eeprom, fuse and lock bits, signature read.
// assumes all pins are asynchronous to clock and are synchronised here;
// the nonvolatile arrays are modelled as local memories.
//
// Overview of operation
// - action select 10 with load strobe pulse captures the command byte
// - command 0x10 selects flash page write
// - action 00, byte select 00 loads address bits 7..0
// - action 00, byte select 01 loads address bits 15..8
// - action 00, byte select 10 loads extended address bits 23..16
// - action 01 loads data low byte, or high byte when low select is 1
// - page latch pulse with low select 1 copies data into page buffer
// - low address bits pick the word, higher bits pick the page
// - write strobe with select 00 under flash write programs page, busy low
// - command 0x00 is a no-op clearing internal write controls
// - command 0x11 fills eeprom buffer; write strobe programs it, busy low
// - command 0x02 drives flash low or high byte by low select
// - command 0x03 drives the addressed eeprom byte
// - command 0x40 writes fuses from data low byte, 0 programs
// - fuse write select 00 low, 01 high, 10 extended; ready marks done
// - command 0x20 programs lock bits; mode 3 refuses boot lock changes
// - lock bits only return unprogrammed by reset, never by write
// - command 0x04 reads fuse low 00, high 11, ext 10, lock 01
// - command 0x08 reads signature byte at low address 0..2
// - signature command, address 0, low select 1 reads calibration byte
// - ready busy output is 0 while programming and 1 when ready
// - data bus driven while output enable is low, following the pin three clocks late
`timescale 1ns/1ps
`include "ppp_defs.svh"
module parallel_program_port #(
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // programmer control pins
  input  wire logic         load_strobe_pin,
  input  wire logic         action_select_hi,
  input  wire logic         action_select_lo,
  input  wire logic         byte_select_lo,
  input  wire logic         byte_select_hi,
  input  wire logic         page_latch_strobe,
  input  wire logic         write_strobe_n,
  input  wire logic         output_enable_n,
  // bidirectional data bus
  input  wire logic [7:0]   data_in,
  output logic [7:0]        data_out,
  output logic              data_oe,
  // status
  output logic              ready_busy_out
);
  import ppp_pkg::*;

  // pin synchronisers: 8 control pins and the data bus
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] pins_raw, sync1, sync2;
  assign pins_raw = {data_in, load_strobe_pin, action_select_hi, action_select_lo,
                     byte_select_lo, byte_select_hi, page_latch_strobe,
                     write_strobe_n, output_enable_n};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  logic [7:0] d_s;
  logic       xs, ahi, alo, bslo, bshi, pl, wr_n, oe_n;
  assign {d_s, xs, ahi, alo, bslo, bshi, pl, wr_n, oe_n} = sync2;

  typedef struct packed {
    logic        xs_q;
    logic        pl_q;
    logic        wr_q;
    byte_t       command;
    logic [23:0] addr;
    byte_t       data_lo;
    byte_t       data_hi;
    byte_t       fuse_low;
    byte_t       fuse_high;
    byte_t       fuse_ext;
    byte_t       lock;
    prog_state_t pstate;
    logic [31:0] timer;
    logic        is_eeprom;
    logic [`FLASH_AW-1:0] drain_idx;
    logic        write_armed;
    byte_t       rdata;
    logic        oe;
  } port_state_t;
  port_state_t state, next_state;

  // page buffers and arrays; page index taken from the address at page write
  logic [15:0] flash_buf [`FLASH_WORDS];
  byte_t       ee_buf    [`EE_BYTES];
  logic [15:0] flash_mem [65536];
  byte_t       ee_mem    [4096];

  // fifo carrying buffered words to the array during programming
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [39:0] f_in_data, f_out_data;

  ppp_fifo #(.WIDTH(40), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // command decode used by the command load path
  function automatic logic is_write_cmd(input byte_t c);
    is_write_cmd = (c == `CMD_WR_FLASH) || (c == `CMD_WR_EEPROM) ||
                   (c == `CMD_WR_FUSE) || (c == `CMD_WR_LOCK);
  endfunction : is_write_cmd

  logic x_rise, p_rise, w_fall;
  assign x_rise = xs && !state.xs_q;
  assign p_rise = pl && !state.pl_q;
  assign w_fall = !wr_n && state.wr_q;

  // drain: while programming, buffered words stream through the fifo
  logic [22:0] page_base;
  assign page_base   = state.addr[22:0];
  assign f_in_valid  = (state.pstate == st_drain);
  // bit 39 tags eeprom words so the array side never mistakes flash data for them
  assign f_in_data   = state.is_eeprom ?
      {1'b1, state.addr[11:`EE_AW], 3'(state.drain_idx), 19'h00000,
       ee_buf[3'(state.drain_idx)]} :
      {1'b0, page_base[15:`FLASH_AW], state.drain_idx, 7'h00,
       flash_buf[state.drain_idx]};
  assign f_out_ready = 1'b1;

  // next state
  always_comb begin
    logic [1:0] act;
    logic [1:0] bsel;
    next_state = state;
    act  = {ahi, alo};
    bsel = {bshi, bslo};
    next_state.xs_q = xs;
    next_state.pl_q = pl;
    next_state.wr_q = wr_n;
    if (x_rise) begin
      case (act)
        `ACT_CMD: begin
          next_state.command = d_s;
          if (d_s == `CMD_NOP) next_state.write_armed = 1'b0;
          else next_state.write_armed = is_write_cmd(d_s);
        end
        `ACT_ADDR: begin
          case (bsel)
            `BSEL_LOW:  next_state.addr[7:0]   = d_s;
            `BSEL_HIGH: next_state.addr[15:8]  = d_s;
            `BSEL_EXT:  next_state.addr[23:16] = d_s;
            default: ;
          endcase
        end
        `ACT_DATA: begin
          if (bslo) next_state.data_hi = d_s;
          else next_state.data_lo = d_s;
        end
        default: ;
      endcase
    end
    // program / drain sequencer
    case (state.pstate)
      st_idle: begin
        if (w_fall && state.write_armed) begin
          case (state.command)
            `CMD_WR_FLASH, `CMD_WR_EEPROM: begin
              if (bsel == `BSEL_LOW) begin
                next_state.is_eeprom = (state.command == `CMD_WR_EEPROM);
                next_state.drain_idx = '0;
                next_state.pstate    = st_drain;
              end
            end
            `CMD_WR_FUSE: begin
              next_state.pstate = st_prog;
              case (bsel)
                `BSEL_LOW:  next_state.fuse_low  = state.data_lo;
                `BSEL_HIGH: next_state.fuse_high = state.data_lo;
                `BSEL_EXT:  next_state.fuse_ext  = state.data_lo;
                default:    next_state.pstate    = st_idle;
              endcase
            end
            `CMD_WR_LOCK: begin
              // bits only move toward programmed; mode 3 freezes boot locks
              if (state.lock[1:0] == `LOCK_MODE3)
                next_state.lock = state.lock & {state.data_lo[7:6], 4'hf,
                                  state.data_lo[1:0]};
              else
                next_state.lock = state.lock & state.data_lo;
              next_state.pstate = st_prog;
            end
            default: ;
          endcase
          next_state.timer = '0;
        end
      end
      st_drain: begin
        if (f_in_ready) begin
          next_state.drain_idx = state.drain_idx + 1'b1;
          if ((state.is_eeprom && state.drain_idx == `FLASH_AW'(`EE_BYTES - 1)) ||
              state.drain_idx == `FLASH_AW'(`FLASH_WORDS - 1))
            next_state.pstate = st_prog;
        end
      end
      st_prog: begin
        next_state.timer = state.timer + 32'h1;
        if (state.timer >= 32'(PROG_CYCLES - 1) && !f_out_valid)
          next_state.pstate = st_idle;
      end
      default: next_state.pstate = st_idle;
    endcase
    // read mux
    next_state.oe = !oe_n;
    next_state.rdata = 8'h00;
    case (state.command)
      `CMD_RD_FLASH:
        next_state.rdata = bslo ? flash_mem[state.addr[15:0]][15:8]
                                : flash_mem[state.addr[15:0]][7:0];
      `CMD_RD_EEPROM:
        next_state.rdata = bslo ? 8'h00 : ee_mem[state.addr[11:0]];
      `CMD_RD_FUSE:
        case (bsel)
          `BSEL_LOW:   next_state.rdata = state.fuse_low;
          `BSEL_FHIGH: next_state.rdata = state.fuse_high;
          `BSEL_EXT:   next_state.rdata = state.fuse_ext;
          default:     next_state.rdata = state.lock;
        endcase
      `CMD_RD_SIG:
        if (bslo)
          next_state.rdata = (state.addr[7:0] == 8'h00) ? `CAL_RST : 8'h00;
        else
          case (state.addr[7:0])
            8'h00:     next_state.rdata = `SIG0;
            8'h01:     next_state.rdata = `SIG1;
            `SIG_LAST: next_state.rdata = `SIG2;
            default:   next_state.rdata = 8'h00;
          endcase
      default: ;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state           <= '0;
      state.xs_q      <= 1'b1;
      state.pl_q      <= 1'b1;
      state.wr_q      <= 1'b1;
      state.fuse_low  <= `FUSE_LOW_RST;
      state.fuse_high <= `FUSE_HIGH_RST;
      state.fuse_ext  <= `FUSE_EXT_RST;
      state.lock      <= `LOCK_RST;
      state.pstate    <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // page buffer latch: word picked by low address bits
  always_ff @(posedge clock) begin
    if (p_rise && bslo && state.pstate == st_idle) begin
      if (state.command == `CMD_WR_EEPROM)
        ee_buf[state.addr[`EE_AW-1:0]] <= state.data_lo;
      else
        flash_buf[state.addr[`FLASH_AW-1:0]] <= {state.data_hi, state.data_lo};
    end
  end

  // array write from fifo; page taken from upper address bits
  always_ff @(posedge clock) begin
    if (f_out_valid) begin
      if (f_out_data[39])
        ee_mem[f_out_data[38:27]] <= f_out_data[7:0];
      else
        flash_mem[f_out_data[38:23]] <= f_out_data[15:0];
    end
  end

  // outputs
  assign data_out       = state.rdata;
  assign data_oe        = state.oe;
  assign ready_busy_out = (state.pstate == st_idle);
endmodule : parallel_program_port

// ---- parallel_program_port_tb_top.sv ----
// self-checking testbench for the parallel program port
// assumes ppp_defs.svh on the include path and a 10 MHz clock
`timescale 1ns/1ps
`include "ppp_defs.svh"
module parallel_program_port_tb_top;
  logic clock, reset_n, ls, ahi, alo, bslo, bshi, pls, wr_n, oe_n, doe, rdy;
  logic [7:0] din, dout;
  int failures, cmp_count;
  parallel_program_port #(.PROG_CYCLES(20)) u_dut (.clock(clock), .reset_n(reset_n),
    .load_strobe_pin(ls), .action_select_hi(ahi), .action_select_lo(alo),
    .byte_select_lo(bslo), .byte_select_hi(bshi), .page_latch_strobe(pls),
    .write_strobe_n(wr_n), .output_enable_n(oe_n), .data_in(din), .data_out(dout),
    .data_oe(doe), .ready_busy_out(rdy));
  ppp_programmer u_prog (.clock(clock), .load_strobe_pin(ls), .action_select_hi(ahi),
    .action_select_lo(alo), .byte_select_lo(bslo), .byte_select_hi(bshi),
    .page_latch_strobe(pls), .write_strobe_n(wr_n), .output_enable_n(oe_n),
    .data_in(din), .data_out(dout), .data_oe(doe), .ready_busy_out(rdy));
  // clock generation
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input string what, input logic [1:0] b, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_prog.read(b, d, ok);
    chk(what, exp, d);
    chk("bus release", 8'h01, {7'h0, ok});
  endtask : rd
  task automatic wrt(input logic [1:0] b, input logic exp);
    logic ok;
    u_prog.write(b, ok);
    chk("busy cycle", {7'h0, exp}, {7'h0, ok});
  endtask : wrt
  task automatic t_sig();
    logic [7:0] sig [3];
    sig = '{`SIG0, `SIG1, `SIG2};
    u_prog.load(`ACT_CMD, 2'h0, `CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      u_prog.load(`ACT_ADDR, `BSEL_LOW, 8'(i));
      rd("signature", 2'h0, sig[i]);
    end
    u_prog.load(`ACT_ADDR, `BSEL_LOW, 8'h00);
    rd("calibration", 2'h1, `CAL_RST);
  endtask : t_sig
  task automatic t_fuse();
    logic [7:0] fv [3];
    logic [1:0] bw [3];
    logic [1:0] br [3];
    fv = '{8'h5a, 8'hc3, 8'hfe};
    bw = '{`BSEL_LOW, `BSEL_HIGH, `BSEL_EXT};
    br = '{2'h0, 2'h3, 2'h2};
    u_prog.load(`ACT_CMD, 2'h0, `CMD_RD_FUSE);
    rd("fuse low", 2'h0, `FUSE_LOW_RST);
    rd("fuse high", 2'h3, `FUSE_HIGH_RST);
    rd("fuse ext", 2'h2, `FUSE_EXT_RST);
    rd("lock", 2'h1, `LOCK_RST);
    u_prog.load(`ACT_CMD, 2'h0, `CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      u_prog.load(`ACT_DATA, 2'h0, fv[i]);
      wrt(bw[i], 1'b1);
    end
    u_prog.load(`ACT_CMD, 2'h0, `CMD_RD_FUSE);
    for (int i = 0; i < 3; i++) rd("fuse back", br[i], fv[i]);
    u_prog.load(`ACT_CMD, 2'h0, `CMD_NOP);
    wrt(2'h0, 1'b0);
    u_prog.load(`ACT_CMD, 2'h0, 8'h55);
    wrt(2'h0, 1'b0);
    u_prog.load(`ACT_CMD, 2'h0, `CMD_RD_FUSE);
    rd("fuse kept", 2'h0, fv[0]);
  endtask : t_fuse
  task automatic t_mem(input logic ee);
    logic [7:0] w [2];
    w = '{8'h00, ee ? 8'h07 : 8'h7f};
    u_prog.load(`ACT_CMD, 2'h0, ee ? `CMD_WR_EEPROM : `CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      u_prog.load(`ACT_ADDR, `BSEL_LOW, w[i]);
      u_prog.load(`ACT_DATA, 2'h0, w[i] ^ 8'h3c);
      if (!ee) u_prog.load(`ACT_DATA, 2'h1, ~w[i]);
      u_prog.latch();
    end
    u_prog.load(`ACT_ADDR, `BSEL_HIGH, 8'h00);
    u_prog.load(`ACT_ADDR, `BSEL_EXT, 8'h00);
    wrt(2'h0, 1'b1);
    u_prog.load(`ACT_CMD, 2'h0, `CMD_NOP);
    u_prog.load(`ACT_CMD, 2'h0, ee ? `CMD_RD_EEPROM : `CMD_RD_FLASH);
    for (int i = 0; i < 2; i++) begin
      u_prog.load(`ACT_ADDR, `BSEL_LOW, w[i]);
      rd("low byte", 2'h0, w[i] ^ 8'h3c);
      if (!ee) rd("high byte", 2'h1, ~w[i]);
    end
  endtask : t_mem
  task automatic t_lock();
    u_prog.load(`ACT_CMD, 2'h0, `CMD_WR_LOCK);
    u_prog.load(`ACT_DATA, 2'h0, 8'hfc);
    wrt(2'h0, 1'b1);
    u_prog.load(`ACT_DATA, 2'h0, 8'hf0);
    wrt(2'h0, 1'b1);
    u_prog.load(`ACT_DATA, 2'h0, 8'hff);
    wrt(2'h0, 1'b1);
    u_prog.load(`ACT_CMD, 2'h0, `CMD_RD_FUSE);
    rd("lock bits", 2'h1, 8'hfc);
  endtask : t_lock
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // watchdog against a hung handshake
  initial begin
    #5_000_000;
    failures++;
    give_verdict();
  end
  // main sequence
  initial begin
    failures = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk("ready after reset", 8'h01, {7'h0, rdy});
    chk("bus idle", 8'h00, {7'h0, doe});
    t_sig();
    t_fuse();
    t_mem(1'b0);
    t_mem(1'b1);
    t_lock();
    give_verdict();
  end
endmodule : parallel_program_port_tb_top
bind parallel_program_port ppp_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clock(clock), .reset_n(reset_n), .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n), .data_oe(data_oe), .ready_busy_out(ready_busy_out));

// ---- ppp_assertions.sv ----
// pin-level checks for the parallel program port
// assumes it is bound to parallel_program_port; one clock domain
`timescale 1ns/1ps
module ppp_assertions #(
  parameter int PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // watched pins
  input wire logic       write_strobe_n,
  input wire logic       output_enable_n,
  input wire logic       data_oe,
  input wire logic       ready_busy_out
);
  logic [16:0] busy_len;
  logic [16:0] since_wr;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // length of the busy phase and age of the last write strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_len <= '0;
      since_wr <= '1;
    end else begin
      busy_len <= ready_busy_out ? '0 : busy_len + 17'h1;
      if ($fell(write_strobe_n)) since_wr <= '0;
      else if (since_wr != '1) since_wr <= since_wr + 17'h1;
    end
  end
  sequence s_oe_held;
    $fell(output_enable_n) ##1 !output_enable_n [*4];
  endsequence
  property p_oe_on;    s_oe_held |=> data_oe;                          endproperty
  property p_oe_rel;   $rose(output_enable_n) |-> ##[1:5] !data_oe;    endproperty
  property p_oe_off;   output_enable_n [*6] |-> !data_oe;              endproperty
  property p_oe_cause; $rose(data_oe) |-> !$past(output_enable_n, 2);  endproperty
  property p_busy_cause; $fell(ready_busy_out) |-> since_wr <= 17'd8;   endproperty
  property p_busy_min; $rose(ready_busy_out) |-> busy_len >= PROG_CYCLES - 1; endproperty
  property p_busy_max; !ready_busy_out |-> busy_len < PROG_CYCLES + 300; endproperty
  property p_idle_ready; since_wr > PROG_CYCLES + 400 |-> ready_busy_out; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  a_oe_rel: assert property (p_oe_rel) else $error("bus not released");
  a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
  a_oe_cause: assert property (p_oe_cause) else $error("drive without enable");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  a_idle_ready: assert property (p_idle_ready) else $error("not ready when idle");
endmodule : ppp_assertions

// ---- ppp_defs.svh ----
// constants for the parallel program port: commands, selects, sizes, timing
// assumes a 10 MHz core clock; included by the package and the design
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH
`define CMD_NOP        8'h00
`define CMD_WR_FLASH   8'h10
`define CMD_WR_EEPROM  8'h11
`define CMD_RD_FLASH   8'h02
`define CMD_RD_EEPROM  8'h03
`define CMD_WR_FUSE    8'h40
`define CMD_WR_LOCK    8'h20
`define CMD_RD_FUSE    8'h04
`define CMD_RD_SIG     8'h08
`define ACT_ADDR       2'h0
`define ACT_DATA       2'h1
`define ACT_CMD        2'h2
`define BSEL_LOW       2'h0
`define BSEL_HIGH      2'h1
`define BSEL_EXT       2'h2
`define BSEL_FHIGH     2'h3
`define FLASH_WORDS    128
`define FLASH_AW       7
`define EE_BYTES       8
`define EE_AW          3
`define LOCK_MODE3     2'h0
`define SIG_LAST       8'h02
`define CLK_MHZ        10
`define PROG_TIME_US   3700
`define PROG_CYCLES    (`PROG_TIME_US * `CLK_MHZ)
`define FIFO_DEPTH     16
`define FUSE_LOW_RST   8'hff
`define FUSE_HIGH_RST  8'hff
`define FUSE_EXT_RST   8'hff
`define LOCK_RST       8'hff
`define SIG0           8'h1e
`define SIG1           8'h5a
`define SIG2           8'ha5
`define CAL_RST        8'h80
`endif

// ---- ppp_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active low reset
`timescale 1ns/1ps
module ppp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } fifo_state_t;
  fifo_state_t state, next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // handshakes
  assign in_ready  = (state.count != (AW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = mem[state.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // pointer update
  always_comb begin
    next_state = state;
    if (push) next_state.wr_ptr = state.wr_ptr + 1'b1;
    if (pop) next_state.rd_ptr = state.rd_ptr + 1'b1;
    next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) state <= '0;
    else state <= next_state;
  end

  // storage
  always_ff @(posedge clock) begin
    if (push) mem[state.wr_ptr] <= in_data;
  end
endmodule : ppp_fifo

// ---- ppp_pkg.sv ----
// types shared by the parallel program port
// assumes ppp_defs.svh is on the include path
`include "ppp_defs.svh"
package ppp_pkg;
  typedef enum logic [1:0] {st_idle, st_prog, st_drain} prog_state_t;
  typedef logic [7:0] byte_t;
endpackage : ppp_pkg

// ---- ppp_programmer.sv ----
// model of the external parallel programmer driving the port pins
// assumes the testbench calls its tasks; pins change 1 ns after a clock edge
`timescale 1ns/1ps
module ppp_programmer (
  // clock
  input wire logic        clock,
  // control pins toward the device
  output logic            load_strobe_pin,
  output logic            action_select_hi,
  output logic            action_select_lo,
  output logic            byte_select_lo,
  output logic            byte_select_hi,
  output logic            page_latch_strobe,
  output logic            write_strobe_n,
  output logic            output_enable_n,
  // data bus and status
  output logic [7:0]      data_in,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe,
  input wire logic        ready_busy_out
);
  logic [7:0] drv;
  logic       drv_en;
  // bus level: device, then us, else a pattern unlike the last value
  assign data_in = data_oe ? data_out : (drv_en ? drv : ~drv);
  // idle pins at time zero
  initial begin
    {action_select_hi, action_select_lo} = 2'h3;
    {byte_select_hi, byte_select_lo} = 2'h0;
    {load_strobe_pin, page_latch_strobe} = 2'h0;
    {write_strobe_n, output_enable_n} = 2'h3;
    drv = 8'h00;
    drv_en = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold
  // one load strobe pulse with action, byte select and data set up
  task automatic load(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    {action_select_hi, action_select_lo} = a;
    {byte_select_hi, byte_select_lo} = b;
    drv = d;
    hold(4);
    load_strobe_pin = 1'b1;
    hold(4);
    load_strobe_pin = 1'b0;
    hold(4);
  endtask : load
  task automatic latch();
    byte_select_lo = 1'b1;
    hold(4);
    page_latch_strobe = 1'b1;
    hold(4);
    page_latch_strobe = 1'b0;
    hold(4);
  endtask : latch
  // write pulse, then wait for busy and its end; ok when both were seen
  task automatic write(input logic [1:0] b, output logic ok);
    logic seen;
    seen = 1'b0;
    {byte_select_hi, byte_select_lo} = b;
    hold(4);
    write_strobe_n = 1'b0;
    hold(4);
    write_strobe_n = 1'b1;
    for (int i = 0; i < 600 && !(seen && ready_busy_out === 1'b1); i++) begin
      @(posedge clock);
      if (ready_busy_out === 1'b0) seen = 1'b1;
    end
    ok = seen && ready_busy_out === 1'b1;
    #1;
  endtask : write
  // read with the bus released; ok when driven and then let go
  task automatic read(input logic [1:0] b, output logic [7:0] d, output logic ok);
    {byte_select_hi, byte_select_lo} = b;
    drv_en = 1'b0;
    output_enable_n = 1'b0;
    hold(6);
    d = data_out;
    ok = data_oe;
    output_enable_n = 1'b1;
    hold(6);
    ok = ok && !data_oe;
    drv_en = 1'b1;
  endtask : read
endmodule : ppp_programmer
